// file: rtl/awr_line_edges.sv
// edge and bus-condition detector for the two serial lines
// assumes scl and sda already synchronous to mclk
`timescale 1ns/100ps
module awr_line_edges
(
  input  wire logic mclk,
  input  wire logic sys_rst,
  input  wire logic clk_en,
  input  wire logic scl_i,
  input  wire logic sda_i,
  output logic      scl_rise,
  output logic      scl_fall,
  output logic      bus_start,
  output logic      bus_stop,
  output logic      sda_now
);

  logic scl_q;
  logic sda_q;

  // idle bus is high on both lines, so reset to one avoids a false scl rise or stop
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end
    else if (clk_en)
    begin
      scl_q <= scl_i;
      sda_q <= sda_i;
    end
  end

  assign sda_now   = sda_i;
  assign scl_rise  = clk_en & scl_i & ~scl_q;
  assign scl_fall  = clk_en & ~scl_i & scl_q;
  assign bus_start = clk_en & scl_i & scl_q & sda_q & ~sda_i;
  assign bus_stop  = clk_en & scl_i & scl_q & ~sda_q & sda_i;

endmodule

// file: rtl/awr_pkg.sv
// constants shared by the converter window-alert register block
// assumes one system clock; the bus side is a plain I2C target
package awr_pkg;

  // bus address of the target, seven bits
  localparam logic [6:0] I2C_ADDR     = 7'h54;

  // register pointer values
  localparam logic [7:0] PTR_RESULT   = 8'h00;
  localparam logic [7:0] PTR_CONFIG   = 8'h02;
  localparam logic [7:0] PTR_UNDER    = 8'h03;
  localparam logic [7:0] PTR_OVER     = 8'h04;
  localparam logic [7:0] PTR_HYST     = 8'h05;

  // layout of result, limit and hysteresis words
  localparam int CONV_W               = 10;
  localparam int CONV_LSB             = 2;
  localparam int CONV_MSB             = 11;
  localparam int FLAG_BIT             = 15;

  // configuration bit positions
  localparam int CFG_FLAG_EN          = 0;
  localparam int CFG_PIN_EN           = 1;
  localparam int CFG_POL_HIGH         = 2;
  localparam int CFG_W                = 3;

  // reset values
  localparam logic [15:0] UNDER_RST   = 16'h0000;
  localparam logic [15:0] OVER_RST    = 16'h0ffc;
  localparam logic [15:0] HYST_RST    = 16'h0000;
  localparam logic [2:0]  CFG_RST     = 3'h0;

  // serial byte shape
  localparam logic [3:0]  BYTE_BITS   = 4'h8;

  typedef enum logic [2:0]
  {
    AWR_IDLE,
    AWR_ADDR,
    AWR_AACK,
    AWR_RX,
    AWR_RXACK,
    AWR_TX,
    AWR_TXACK
  } awr_state_t;

endpackage

// file: rtl/awr_top.sv
// window-alert register block of a ten-bit converter behind an I2C target
// assumes scl and sda sampled synchronous to mclk, sda open drain outside
`timescale 1ns/100ps
module awr_top
#(
  parameter logic [6:0] DEV_ADDR = awr_pkg::I2C_ADDR,
  parameter int         CW       = awr_pkg::CONV_W
)
(
  input  wire logic          mclk,
  input  wire logic          sys_rst,
  input  wire logic          clk_en,
  input  wire logic          scl_i,
  input  wire logic          sda_i,
  output logic               sda_o,
  output logic               sda_oe,
  input  wire logic          conv_valid,
  input  wire logic [CW-1:0] conv_data,
  output logic               alert_pin
);

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  awr_pkg::awr_state_t state_q;
  logic [3:0]          bitcnt_q;
  logic [7:0]          shift_q;
  logic [7:0]          tx_q;
  logic [7:0]          ptr_q;
  logic [7:0]          msb_q;
  logic [15:0]         rd_word_q;
  logic [1:0]          byte_idx_q;
  logic                rw_q;
  logic                ack_ok_q;
  logic [15:0]         under_q;
  logic [15:0]         over_q;
  logic [15:0]         hyst_q;
  logic [awr_pkg::CFG_W-1:0] cfg_q;
  logic                alert_pin_q;

  logic                scl_rise;
  logic                scl_fall;
  logic                bus_start;
  logic                bus_stop;
  logic                sda_now;
  logic [CW-1:0]       result;
  logic                under_alert;
  logic                over_alert;
  logic                alert;
  logic [7:0]          rx_byte;
  logic [15:0]         rd_now;

  ////////////////////////////////////////////////////////////////////////////
  // read decode, used only when a read starts; follow-on bytes come from the snapshot

  function automatic logic [15:0] reg_read
  (
    input logic [7:0] ptr
  );
    logic [15:0] w;
    w = 16'h0000;
    case (ptr)
      awr_pkg::PTR_RESULT:
      begin
        w[awr_pkg::CONV_MSB:awr_pkg::CONV_LSB] = result;
        w[awr_pkg::FLAG_BIT] = alert & cfg_q[awr_pkg::CFG_FLAG_EN];
      end
      awr_pkg::PTR_CONFIG: w[awr_pkg::CFG_W-1:0] = cfg_q;
      awr_pkg::PTR_UNDER:  w = under_q;
      awr_pkg::PTR_OVER:   w = over_q;
      awr_pkg::PTR_HYST:   w = hyst_q;
      default:             w = 16'h0000;
    endcase
    return w;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // line edges and window comparator

  awr_line_edges u_edges
  (
    .mclk      (mclk),
    .sys_rst   (sys_rst),
    .clk_en    (clk_en),
    .scl_i     (scl_i),
    .sda_i     (sda_i),
    .scl_rise  (scl_rise),
    .scl_fall  (scl_fall),
    .bus_start (bus_start),
    .bus_stop  (bus_stop),
    .sda_now   (sda_now)
  );

  awr_window #(.CW(CW)) u_window
  (
    .mclk       (mclk),
    .sys_rst    (sys_rst),
    .clk_en     (clk_en),
    .conv_valid (conv_valid),
    .conv_data  (conv_data),
    .under_lim  (under_q[awr_pkg::CONV_MSB:awr_pkg::CONV_LSB]),
    .over_lim   (over_q[awr_pkg::CONV_MSB:awr_pkg::CONV_LSB]),
    .hyst       (hyst_q[awr_pkg::CONV_MSB:awr_pkg::CONV_LSB]),
    .result_q   (result),
    .under_q    (under_alert),
    .over_q     (over_alert)
  );

  assign alert   = under_alert | over_alert;
  assign rx_byte = shift_q;

  // the decode reads live state, so a comb process keeps it current
  always_comb
  begin
    rd_now = reg_read(ptr_q);
  end

  ////////////////////////////////////////////////////////////////////////////
  // serial target state machine

  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state_q    <= awr_pkg::AWR_IDLE;
      bitcnt_q   <= 4'h0;
      shift_q    <= 8'h00;
      tx_q       <= 8'hff;
      rw_q       <= 1'b0;
      ack_ok_q   <= 1'b0;
      byte_idx_q <= 2'h0;
    end
    else if (clk_en)
    begin
      if (bus_stop)
        state_q <= awr_pkg::AWR_IDLE;
      else if (bus_start)
      begin
        // repeated start lands here too
        state_q    <= awr_pkg::AWR_ADDR;
        bitcnt_q   <= 4'h0;
        byte_idx_q <= 2'h0;
      end
      else
      begin
        case (state_q)
          awr_pkg::AWR_IDLE: ;
          awr_pkg::AWR_ADDR:
          begin
            if (scl_rise)
            begin
              shift_q  <= {shift_q[6:0], sda_now};
              bitcnt_q <= bitcnt_q + 4'h1;
            end
            else if (scl_fall && bitcnt_q == awr_pkg::BYTE_BITS)
            begin
              rw_q <= rx_byte[0];
              if (rx_byte[7:1] == DEV_ADDR)
                state_q <= awr_pkg::AWR_AACK;
              else
                state_q <= awr_pkg::AWR_IDLE;
            end
          end
          awr_pkg::AWR_AACK:
          begin
            if (scl_fall)
            begin
              bitcnt_q <= 4'h0;
              if (rw_q)
              begin
                tx_q    <= rd_now[15:8];
                state_q <= awr_pkg::AWR_TX;
              end
              else
                state_q <= awr_pkg::AWR_RX;
            end
          end
          awr_pkg::AWR_RX:
          begin
            if (scl_rise)
            begin
              shift_q  <= {shift_q[6:0], sda_now};
              bitcnt_q <= bitcnt_q + 4'h1;
            end
            else if (scl_fall && bitcnt_q == awr_pkg::BYTE_BITS)
              state_q <= awr_pkg::AWR_RXACK;
          end
          awr_pkg::AWR_RXACK:
          begin
            if (scl_fall)
            begin
              bitcnt_q   <= 4'h0;
              state_q    <= awr_pkg::AWR_RX;
              // after a full data word, further pairs go to the same register
              byte_idx_q <= (byte_idx_q == 2'h2) ? 2'h1 : byte_idx_q + 2'h1;
            end
          end
          awr_pkg::AWR_TX:
          begin
            if (scl_fall)
            begin
              if (bitcnt_q == 4'h7)
                state_q <= awr_pkg::AWR_TXACK;
              else
              begin
                tx_q     <= {tx_q[6:0], 1'b1};
                bitcnt_q <= bitcnt_q + 4'h1;
              end
            end
          end
          awr_pkg::AWR_TXACK:
          begin
            if (scl_rise)
              ack_ok_q <= ~sda_now;
            else if (scl_fall)
            begin
              bitcnt_q   <= 4'h0;
              byte_idx_q <= byte_idx_q + 2'h1;
              // a missing acknowledge ends the read; wait for stop
              if (ack_ok_q)
              begin
                tx_q    <= byte_idx_q[0] ? rd_word_q[15:8] : rd_word_q[7:0];
                state_q <= awr_pkg::AWR_TX;
              end
              else
                state_q <= awr_pkg::AWR_IDLE;
            end
          end
          default: state_q <= awr_pkg::AWR_IDLE;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read word snapshot, so both bytes of one word belong together

  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
      rd_word_q <= 16'h0000;
    else if (clk_en && state_q == awr_pkg::AWR_AACK && scl_fall && rw_q)
      rd_word_q <= reg_read(ptr_q);
  end

  ////////////////////////////////////////////////////////////////////////////
  // pointer and register writes, taken when a received byte is acknowledged

  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      ptr_q   <= awr_pkg::PTR_RESULT;
      msb_q   <= 8'h00;
      under_q <= awr_pkg::UNDER_RST;
      over_q  <= awr_pkg::OVER_RST;
      hyst_q  <= awr_pkg::HYST_RST;
      cfg_q   <= awr_pkg::CFG_RST;
    end
    else if (clk_en && state_q == awr_pkg::AWR_RXACK && scl_fall)
    begin
      case (byte_idx_q)
        2'h0: ptr_q <= rx_byte;
        2'h1: msb_q <= rx_byte;
        default:
        begin
          case (ptr_q)
            awr_pkg::PTR_CONFIG: cfg_q <= rx_byte[awr_pkg::CFG_W-1:0];
            awr_pkg::PTR_UNDER:  under_q <= {msb_q, rx_byte};
            awr_pkg::PTR_OVER:   over_q  <= {msb_q, rx_byte};
            awr_pkg::PTR_HYST:   hyst_q  <= {msb_q, rx_byte};
            default: ;
          endcase
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // alert pin, registered so it never glitches during limit writes

  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
      alert_pin_q <= 1'b0;
    else if (clk_en)
    begin
      if (!cfg_q[awr_pkg::CFG_PIN_EN])
        alert_pin_q <= 1'b0;
      else if (cfg_q[awr_pkg::CFG_POL_HIGH])
        alert_pin_q <= alert;
      else
        alert_pin_q <= ~alert;
    end
  end

  assign alert_pin = alert_pin_q;

  ////////////////////////////////////////////////////////////////////////////
  // open-drain data line: only ever pulls low

  assign sda_o  = 1'b0;
  assign sda_oe = (state_q == awr_pkg::AWR_AACK)
                | (state_q == awr_pkg::AWR_RXACK)
                | (state_q == awr_pkg::AWR_TX && !tx_q[7]);

endmodule

// file: rtl/awr_window.sv
// result word holder and window comparator with hysteresis
// assumes conv_valid is a one-cycle pulse per finished conversion
`timescale 1ns/100ps
module awr_window
#(
  parameter int CW = awr_pkg::CONV_W
)
(
  input  wire logic          mclk,
  input  wire logic          sys_rst,
  input  wire logic          clk_en,
  input  wire logic          conv_valid,
  input  wire logic [CW-1:0] conv_data,
  input  wire logic [CW-1:0] under_lim,
  input  wire logic [CW-1:0] over_lim,
  input  wire logic [CW-1:0] hyst,
  output logic      [CW-1:0] result_q,
  output logic               under_q,
  output logic               over_q
);

  logic [CW:0] low_clear;
  logic [CW:0] high_test;
  logic        under_d;
  logic        over_d;

  // widened sums so a big hysteresis never wraps
  assign low_clear = {1'b0, under_lim} + {1'b0, hyst};
  assign high_test = {1'b0, conv_data} + {1'b0, hyst};

  always_comb
  begin
    under_d = under_q;
    over_d  = over_q;
    if (conv_data < under_lim)
      under_d = 1'b1;
    else if ({1'b0, conv_data} > low_clear)
      under_d = 1'b0;
    if (conv_data > over_lim)
      over_d = 1'b1;
    else if (high_test < {1'b0, over_lim})
      over_d = 1'b0;
  end

  // result and alert state move together on the same edge
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      result_q <= '0;
      under_q  <= 1'b0;
      over_q   <= 1'b0;
    end
    else if (clk_en && conv_valid)
    begin
      result_q <= conv_data;
      under_q  <= under_d;
      over_q   <= over_d;
    end
  end

endmodule

// file: testbench/awr_host_model.sv
// host controller on the serial bus, behavioural
// assumes a pull-up on sda outside; scl only driven here
`timescale 1ns/100ps
module awr_host_model
(
  input  wire logic mclk,
  input  wire logic sda_w,
  output logic      scl_o,
  output logic      sda_pull
);
  initial
  begin
    scl_o    = 1'b1;
    sda_pull = 1'b0;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  // 8 mclk low and high, well over the 3 the target needs
  task automatic bitx(input logic d, output logic q);
    sda_pull = ~d;
    wt(4);
    scl_o = 1'b1;
    wt(4);
    q = sda_w;
    wt(4);
    scl_o = 1'b0;
    wt(4);
  endtask
  task automatic start_c;
    sda_pull = 1'b0;
    wt(4);
    scl_o = 1'b1;
    wt(4);
    sda_pull = 1'b1;
    wt(4);
    scl_o = 1'b0;
    wt(4);
  endtask
  task automatic stop_c;
    sda_pull = 1'b1;
    wt(4);
    scl_o = 1'b1;
    wt(4);
    sda_pull = 1'b0;
    wt(4);
  endtask
  task automatic wbyte(input logic [7:0] b, output logic ack);
    logic q;
    for (int i = 7; i >= 0; i--)
      bitx(b[i], q);
    bitx(1'b1, q);
    ack = ~q;
  endtask
  // last byte gets a nack so the target lets go of sda
  task automatic rbyte(input logic last, output logic [7:0] b);
    logic q;
    for (int i = 7; i >= 0; i--)
    begin
      bitx(1'b1, q);
      b[i] = q;
    end
    bitx(last, q);
  endtask
  task automatic addr_only(input logic [7:0] a, output logic ack);
    start_c;
    wbyte(a, ack);
    stop_c;
  endtask
  task automatic wr_reg(input logic [7:0] p, input logic [15:0] d);
    logic a;
    start_c;
    wbyte(8'ha8, a);
    wbyte(p, a);
    wbyte(d[15:8], a);
    wbyte(d[7:0], a);
    stop_c;
  endtask
  task automatic rd_reg(input logic [7:0] p, output logic [15:0] d,
                        output logic ok);
    logic a0;
    logic a1;
    logic a2;
    start_c;
    wbyte(8'ha8, a0);
    wbyte(p, a1);
    start_c;
    wbyte(8'ha9, a2);
    rbyte(1'b0, d[15:8]);
    rbyte(1'b1, d[7:0]);
    stop_c;
    ok = a0 & a1 & a2;
  endtask
endmodule

// file: testbench/awr_top_asserts.sv
// port-level checker for the window-alert register block
// assumes scl held low and high for several mclk by the host
`timescale 1ns/100ps
module awr_top_chk
#(
  parameter logic [6:0] DEV_ADDR = 7'h54,
  parameter int         CW       = 10
)
(
  input wire logic          mclk,
  input wire logic          sys_rst,
  input wire logic          clk_en,
  input wire logic          scl_i,
  input wire logic          sda_i,
  input wire logic          sda_o,
  input wire logic          sda_oe,
  input wire logic          conv_valid,
  input wire logic [CW-1:0] conv_data,
  input wire logic          alert_pin
);
  logic [3:0] cnt_q;
  logic [7:0] sh_q;
  logic       ok_q;
  logic       scl_p_q;
  logic       sda_p_q;
  logic       start_w;
  logic       rise_w;
  //////////////////////////////////////////////////////////////////////////////
  // count scl rises since start; 15 before any start so nothing is expected
  assign start_w = scl_i & scl_p_q & sda_p_q & ~sda_i;
  assign rise_w  = scl_i & ~scl_p_q;
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
      cnt_q   <= 4'hf;
      sh_q    <= 8'h00;
      ok_q    <= 1'b0;
    end
    else
    begin
      scl_p_q <= scl_i;
      sda_p_q <= sda_i;
      if (start_w)
        cnt_q <= 4'h0;
      else if (rise_w && cnt_q != 4'hf)
        cnt_q <= cnt_q + 4'h1;
      if (rise_w)
        sh_q <= {sh_q[6:0], sda_i};
      if (start_w)
        ok_q <= 1'b0;
      else if (rise_w && cnt_q == 4'h7)
        ok_q <= (sh_q[6:0] == DEV_ADDR);
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  property p_sda_o;
    !sda_o;
  endproperty
  a_sda_o: assert property (p_sda_o) else $error("sda_o not low");
  property p_early;
    cnt_q < 4'h8 |-> !sda_oe;
  endproperty
  a_early: assert property (p_early) else $error("drive in address");
  property p_foreign;
    cnt_q >= 4'h8 && !ok_q |-> !sda_oe;
  endproperty
  a_foreign: assert property (p_foreign) else $error("foreign ack");
  property p_addr_ack;
    $fell(scl_i) && cnt_q == 4'h8 && ok_q |-> ##[1:3] sda_oe;
  endproperty
  a_addr_ack: assert property (p_addr_ack) else $error("no ack");
  property p_oe_scl_low;
    $changed(sda_oe) |-> !scl_i;
  endproperty
  a_oe_scl_low: assert property (p_oe_scl_low)
    else $error("sda moved");
  property p_pin_cause;
    $changed(alert_pin) |-> $past(conv_valid, 2) || !scl_i;
  endproperty
  a_pin_cause: assert property (p_pin_cause) else $error("pin moved");
  property p_freeze;
    !$past(clk_en) |-> $stable(sda_oe) && $stable(alert_pin);
  endproperty
  a_freeze: assert property (p_freeze) else $error("moved frozen");
  property p_reset_quiet;
    $past(sys_rst) |-> !sda_oe && !alert_pin;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet)
    else $error("not quiet");
endmodule
bind awr_top awr_top_chk #(.DEV_ADDR(DEV_ADDR), .CW(CW)) u_chk
(
  .mclk       (mclk),
  .sys_rst    (sys_rst),
  .clk_en     (clk_en),
  .scl_i      (scl_i),
  .sda_i      (sda_i),
  .sda_o      (sda_o),
  .sda_oe     (sda_oe),
  .conv_valid (conv_valid),
  .conv_data  (conv_data),
  .alert_pin  (alert_pin)
);

// file: testbench/tb_top.sv
// self-checking bench: register access and alert window over the bus
// assumes the host model and checker are compiled alongside
`timescale 1ns/100ps
module tb_top;
  localparam logic [7:0] BAD [4] = '{8'haa, 8'ha6, 8'h28, 8'hab};
  localparam logic [9:0] CV [10] = '{10'h064, 10'h03f, 10'h050, 10'h051,
    10'h301, 10'h2f0, 10'h2ef, 10'h3ff, 10'h000, 10'h1f4};
  localparam logic AL [10] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0,
    1'b1, 1'b1, 1'b0};
  logic       mclk;
  logic       sys_rst;
  logic       clk_en;
  logic       conv_valid;
  logic [9:0] conv_data;
  logic       sda_o;
  logic       sda_oe;
  logic       alert_pin;
  logic       scl;
  logic       sda_pull;
  logic       sda_w;
  logic       ok;
  logic [15:0] rd;
  int         n_mismatch;
  int         n_tests;
  assign sda_w = ~(sda_oe | sda_pull);
  awr_top u_dut
  (
    .mclk       (mclk),
    .sys_rst    (sys_rst),
    .clk_en     (clk_en),
    .scl_i      (scl),
    .sda_i      (sda_w),
    .sda_o      (sda_o),
    .sda_oe     (sda_oe),
    .conv_valid (conv_valid),
    .conv_data  (conv_data),
    .alert_pin  (alert_pin)
  );
  awr_host_model u_host
  (
    .mclk     (mclk),
    .sda_w    (sda_w),
    .scl_o    (scl),
    .sda_pull (sda_pull)
  );
  initial
  begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [15:0] seen, exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic rdc(input logic [7:0] p, input logic [15:0] exp,
                     input string nm);
    u_host.rd_reg(p, rd, ok);
    chk(nm, rd, exp);
    chk("read ack", {15'h0, ok}, 16'h0001);
  endtask
  // pin looked at two edges after the update edge
  task automatic conv(input logic [9:0] v, input logic al);
    conv_valid = 1'b1;
    conv_data  = v;
    @(posedge mclk);
    #1 conv_valid = 1'b0;
    repeat (2) @(posedge mclk);
    #1 chk("alert_pin", {15'h0, alert_pin}, {15'h0, al});
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    n_mismatch = 0;
    n_tests    = 0;
    sys_rst    = 1'b1;
    clk_en     = 1'b1;
    conv_valid = 1'b0;
    conv_data  = 10'h000;
    repeat (12) @(posedge mclk);
    #1 sys_rst = 1'b0;
    repeat (2) @(posedge mclk);
    #1;
    rdc(8'h00, 16'h0000, "result");
    rdc(8'h03, 16'h0000, "under");
    rdc(8'h04, 16'h0ffc, "over");
    rdc(8'h05, 16'h0000, "hyst");
    rdc(8'h07, 16'h0000, "unmapped");
    $display("test reset_values done");
    foreach (BAD[i])
    begin
      u_host.addr_only(BAD[i], ok);
      chk("foreign ack", {15'h0, ok}, 16'h0000);
    end
    u_host.addr_only(8'ha8, ok);
    chk("own ack", {15'h0, ok}, 16'h0001);
    $display("test addressing done");
    u_host.wr_reg(awr_pkg::PTR_UNDER, 16'h0100);
    u_host.wr_reg(awr_pkg::PTR_OVER, 16'h0c00);
    u_host.wr_reg(awr_pkg::PTR_HYST, 16'h0040);
    u_host.wr_reg(awr_pkg::PTR_CONFIG, 16'h0007);
    u_host.wr_reg(awr_pkg::PTR_RESULT, 16'h1234);
    rdc(awr_pkg::PTR_UNDER, 16'h0100, "under");
    rdc(awr_pkg::PTR_OVER, 16'h0c00, "over");
    rdc(awr_pkg::PTR_HYST, 16'h0040, "hyst");
    rdc(awr_pkg::PTR_RESULT, 16'h0000, "result");
    $display("test limits done");
    // walks across both limits and both hysteresis edges
    for (int i = 0; i < 10; i++)
    begin
      conv(CV[i], AL[i]);
      rdc(8'h00, {AL[i], 3'h0, CV[i], 2'h0}, "result");
    end
    $display("test window done");
    conv_valid = 1'b1;
    conv_data  = 10'd63;
    @(posedge mclk);
    #1 conv_data = 10'd100;
    @(posedge mclk);
    #1 conv_valid = 1'b0;
    repeat (2) @(posedge mclk);
    #1 chk("alert_pin", {15'h0, alert_pin}, 16'h0000);
    rdc(8'h00, 16'h0190, "result");
    clk_en     = 1'b0;
    conv_valid = 1'b1;
    conv_data  = 10'd1023;
    @(posedge mclk);
    #1 conv_valid = 1'b0;
    @(posedge mclk);
    #1 clk_en = 1'b1;
    rdc(8'h00, 16'h0190, "frozen result");
    $display("test back_to_back done");
    u_host.wr_reg(awr_pkg::PTR_CONFIG, 16'h0000);
    conv(10'd1023, 1'b0);
    rdc(8'h00, 16'h0ffc, "flag off");
    $display("test disabled done");
    // low polarity: pin is the inverse of the alert state
    u_host.wr_reg(awr_pkg::PTR_CONFIG, 16'h0003);
    chk("alert_pin", {15'h0, alert_pin}, 16'h0000);
    conv(10'h1f4, 1'b1);
    rdc(8'h00, 16'h07d0, "low polarity");
    $display("test polarity done");
    report_and_stop;
  end
  // about 40 bus accesses of under 1000 cycles each; 75000 cycles is ample
  initial
  begin
    #600000;
    n_mismatch++;
    $display("watchdog expired");
    report_and_stop;
  end
endmodule
